//--- verilog/lsf_link_supervisor.sv
// Serial link watchdog, input deglitchers, clock monitor and fail mode control
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
// ============================================================================
// Behaviour
// - Any link fault forces fail mode
// - Unchanged alive bit in a word flags fault
// - No valid frame within watchdog period flags fault
// - Edge count not multiple of sixteen flags fault
// - Stuck data caught by alive bit check
// - Link fault flag readable in device status
// - Flag held in fail mode, cleared leaving it
// - Request pin forces fail after 200 us high
// - Direct input held high takes its channel
// - Reset pin deglitched on falling edge only
// - Clock pin deglitched on both edges
// - Clock monitor starts at reset rise, 100 Hz
// - Clock failure: outputs follow channel control directly
// - Clock fail clears after condition gone and read
// - Switch drive follows channel 6 in normal mode
// - Switch drive off in sleep or fail mode
// - Fail mode: channels follow direct inputs
// - Request pin level readable in device status
// ============================================================================

// ============================================================================
// Deglitch filter with separate delays per edge
// ============================================================================
module lsf_deglitch #(
  parameter int RISE_CYC = 1,
  parameter int FALL_CYC = 1,
  parameter int CW = 16,
  parameter logic INIT = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Synchronised input and filtered output
  input wire logic din,
  output logic dout
);
  logic [CW-1:0] cnt_reg; // Cycles the input has differed
  logic flip; // Input differed long enough

  generate
    if (RISE_CYC >= 2 ** CW || FALL_CYC >= 2 ** CW)
    begin : g_chk
      $error("lsf_deglitch: delay does not fit counter");
    end
  endgenerate

  // Zero delay passes that edge at once
  always_comb
  begin
    if (din)
      flip = (RISE_CYC == 0) || (cnt_reg == CW'(RISE_CYC - 1));
    else
      flip = (FALL_CYC == 0) || (cnt_reg == CW'(FALL_CYC - 1));
  end

  // Counter restarts whenever the input agrees with the output
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_reg <= '0;
    else if (din == dout || flip)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_reg + CW'(1);
  end

  // Output takes the input once it has stood long enough
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      dout <= INIT;
    else if (din != dout && flip)
      dout <= din;
  end
endmodule

// ============================================================================
// Top: link supervisor with APB registers
// ============================================================================
module lsf_link_supervisor #(
  parameter int NCH = 4,
  parameter int IN_DGL_CYC = lsf_pkg::IN_DGL_CYC,
  parameter int WD_SHORT_CYC = lsf_pkg::WD_SHORT_CYC,
  parameter int WD_LONG_CYC = lsf_pkg::WD_LONG_CYC,
  parameter int CLK_LOW_CYC = lsf_pkg::CLK_LOW_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial link pins
  input wire logic link_sclk,
  input wire logic link_cs_n,
  input wire logic link_mosi,
  // Direct pins
  input wire logic failsafe_request_input,
  input wire logic [NCH-1:0] direct_channel_input,
  input wire logic reset_sleep_n,
  input wire logic ext_clk_in,
  // Channel drive sources
  input wire logic [NCH-1:0] channel_control_signal,
  input wire logic [NCH-1:0] pwm_drive,
  // Outputs
  output logic [NCH-1:0] channel_out,
  output logic external_switch_drive,
  output logic fail_mode,
  output logic irq
);
  localparam int SW = NCH + 6; // Synchronised pin count
  localparam int WDW = 22; // Watchdog counter width
  localparam int CMW = 18; // Clock monitor counter width

  generate
    if (WD_LONG_CYC >= 2 ** WDW || WD_SHORT_CYC >= 2 ** WDW || CLK_LOW_CYC >= 2 ** CMW || NCH < 1)
    begin : g_chk
      $error("lsf_link_supervisor: parameter out of range");
    end
  endgenerate

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [SW-1:0] sync1_reg; // First stage, read only by second
  logic [SW-1:0] sync2_reg; // Second stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_reg <= {{(SW - 2){1'b0}}, 2'h2}; // Chip select pin idles high
      sync2_reg <= {{(SW - 2){1'b0}}, 2'h2}; // No false frame start after reset
    end
    else
    begin
      sync1_reg <= {direct_channel_input, ext_clk_in, reset_sleep_n, failsafe_request_input,
                    link_mosi, link_cs_n, link_sclk};
      sync2_reg <= sync1_reg;
    end
  end
  logic s_sclk, s_cs_n, s_mosi, s_req, s_rst, s_clk;
  logic [NCH-1:0] s_din;
  assign {s_din, s_clk, s_rst, s_req, s_mosi, s_cs_n, s_sclk} = sync2_reg;

  // ==========================================================================
  // Deglitchers
  // ==========================================================================
  logic failsafe_request_filtered; // Filtered request
  logic [NCH-1:0] direct_input_filtered; // Filtered direct inputs
  logic awake; // Filtered reset pin, high when awake
  logic clk_filt; // Filtered clock pin

  lsf_deglitch #(.RISE_CYC(IN_DGL_CYC), .FALL_CYC(0), .CW(16), .INIT(1'b0)) u_req (
    .clk(pclk), .rst_n(presetn), .din(s_req), .dout(failsafe_request_filtered));
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_din
      lsf_deglitch #(.RISE_CYC(IN_DGL_CYC), .FALL_CYC(0), .CW(16), .INIT(1'b0)) u_din (
        .clk(pclk), .rst_n(presetn), .din(s_din[gi]), .dout(direct_input_filtered[gi]));
    end
  endgenerate
  lsf_deglitch #(.RISE_CYC(0), .FALL_CYC(lsf_pkg::RST_DGL_CYC), .CW(16), .INIT(1'b0)) u_rst (
    .clk(pclk), .rst_n(presetn), .din(s_rst), .dout(awake));
  lsf_deglitch #(.RISE_CYC(lsf_pkg::CLK_DGL_CYC), .FALL_CYC(lsf_pkg::CLK_DGL_CYC), .CW(16),
    .INIT(1'b0)) u_clk (.clk(pclk), .rst_n(presetn), .din(s_clk), .dout(clk_filt));

  // ==========================================================================
  // Serial frame checker
  // ==========================================================================
  logic sclk_d_reg; // Previous serial clock level
  logic cs_d_reg; // Previous chip select active
  logic [3:0] bit_cnt_reg; // Edges modulo sixteen
  logic [14:0] shift_reg; // Bits received so far in the word
  logic word_seen_reg; // Frame held at least one word
  logic tog_bad_reg; // Frame held an alive bit error
  logic ch6_pend_reg; // Channel 6 setting from this frame
  logic alive_prev_reg; // Alive bit of last word
  logic alive_seen_reg; // A word has been seen since reset
  logic ch6_reg; // Accepted channel 6 setting
  logic cs_act, sclk_rise, frame_start, frame_end, word_done;
  logic [15:0] word;
  logic tog_evt, len_evt, wd_evt, valid_frame, link_fault_evt;

  assign cs_act = !s_cs_n;
  assign sclk_rise = s_sclk && !sclk_d_reg && cs_act;
  assign frame_start = cs_act && !cs_d_reg;
  assign frame_end = !cs_act && cs_d_reg;
  assign word_done = sclk_rise && (bit_cnt_reg == 4'hF);
  assign word = {shift_reg, s_mosi};
  // Static data or dead supply gives an unchanged alive bit
  assign tog_evt = word_done && alive_seen_reg && (word[lsf_pkg::ALIVE_BIT] == alive_prev_reg);
  assign len_evt = frame_end && (bit_cnt_reg != 4'h0);
  assign valid_frame = frame_end && (bit_cnt_reg == 4'h0) && word_seen_reg && !tog_bad_reg;

  // Edge history of the link pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sclk_d_reg <= 1'b0;
      cs_d_reg <= 1'b0;
    end
    else
    begin
      sclk_d_reg <= s_sclk;
      cs_d_reg <= cs_act;
    end
  end

  // Word assembly and per-frame flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bit_cnt_reg <= 4'h0;
      shift_reg <= 15'h0000;
      word_seen_reg <= 1'b0;
      tog_bad_reg <= 1'b0;
      ch6_pend_reg <= 1'b0;
    end
    else if (frame_start)
    begin
      bit_cnt_reg <= 4'h0;
      word_seen_reg <= 1'b0;
      tog_bad_reg <= 1'b0;
    end
    else if (sclk_rise)
    begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      shift_reg <= word[14:0];
      if (word_done)
      begin
        word_seen_reg <= 1'b1;
        ch6_pend_reg <= word[lsf_pkg::CH6_BIT];
        if (tog_evt)
          tog_bad_reg <= 1'b1;
      end
    end
  end

  // Alive bit history across frames
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      alive_prev_reg <= 1'b0;
      alive_seen_reg <= 1'b0;
    end
    else if (word_done)
    begin
      alive_prev_reg <= word[lsf_pkg::ALIVE_BIT];
      alive_seen_reg <= 1'b1;
    end
  end

  // Channel 6 setting taken from valid frames only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ch6_reg <= 1'b0;
    else if (valid_frame)
      ch6_reg <= ch6_pend_reg;
  end

  // ==========================================================================
  // Watchdog
  // ==========================================================================
  logic range_sel_reg; // timeout_range_select
  logic [WDW-1:0] wd_cnt_reg;
  logic [WDW-1:0] wd_limit;
  assign wd_limit = range_sel_reg ? WDW'(WD_LONG_CYC - 1) : WDW'(WD_SHORT_CYC - 1);
  // Compare at or above: a shorter range chosen mid-count must still expire
  assign wd_evt = awake && (wd_cnt_reg >= wd_limit);

  // Counts while awake, restarts on a valid frame or on expiry
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wd_cnt_reg <= '0;
    else if (!awake || valid_frame || wd_evt)
      wd_cnt_reg <= '0;
    else
      wd_cnt_reg <= wd_cnt_reg + WDW'(1);
  end

  // ==========================================================================
  // Fail mode and link fault flag
  // ==========================================================================
  logic link_fault_flag; // Sticky while in fail mode
  logic tog_err_reg, wd_err_reg, len_err_reg; // Fault causes
  logic resume_req; // Software asks to leave fail mode
  logic leave_fail;
  assign link_fault_evt = tog_evt || len_evt || wd_evt;
  assign leave_fail = fail_mode && resume_req && !failsafe_request_filtered && !link_fault_evt;

  // Entered on a fault or filtered request, left only on request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fail_mode <= 1'b0;
    else if (link_fault_evt || failsafe_request_filtered)
      fail_mode <= 1'b1;
    else if (leave_fail)
      fail_mode <= 1'b0;
  end

  // Flag and causes set on fault, cleared only on fail to normal step
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link_fault_flag <= 1'b0;
      tog_err_reg <= 1'b0;
      wd_err_reg <= 1'b0;
      len_err_reg <= 1'b0;
    end
    else if (link_fault_evt)
    begin
      link_fault_flag <= 1'b1;
      tog_err_reg <= tog_err_reg || tog_evt;
      wd_err_reg <= wd_err_reg || wd_evt;
      len_err_reg <= len_err_reg || len_evt;
    end
    else if (leave_fail)
    begin
      link_fault_flag <= 1'b0;
      tog_err_reg <= 1'b0;
      wd_err_reg <= 1'b0;
      len_err_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Clock monitor
  // ==========================================================================
  logic clk_filt_d_reg; // Previous filtered clock
  logic [CMW-1:0] cm_cnt_reg; // Cycles since last filtered clock edge
  logic clk_cond_reg; // Clock failure condition now
  logic clk_fail_reg; // Latched clock failure
  logic qstat_read; // Quick status read accepted
  logic clk_edge;
  assign clk_edge = clk_filt != clk_filt_d_reg;

  // Held idle in sleep so monitoring begins at reset pin rise
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clk_filt_d_reg <= 1'b0;
      cm_cnt_reg <= '0;
      clk_cond_reg <= 1'b0;
    end
    else
    begin
      clk_filt_d_reg <= clk_filt;
      if (!awake || clk_edge)
      begin
        cm_cnt_reg <= '0;
        clk_cond_reg <= 1'b0;
      end
      else if (cm_cnt_reg == CMW'(CLK_LOW_CYC - 1))
        clk_cond_reg <= 1'b1;
      else
        cm_cnt_reg <= cm_cnt_reg + CMW'(1);
    end
  end

  // Latch clears only with condition gone and a quick status read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clk_fail_reg <= 1'b0;
    else if (clk_cond_reg)
      clk_fail_reg <= 1'b1;
    else if (qstat_read)
      clk_fail_reg <= 1'b0;
  end

  // ==========================================================================
  // Output steering
  // ==========================================================================
  // Direct inputs in fail mode, then held direct, then clock fail, then PWM
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      channel_out <= '0;
    else
      for (int i = 0; i < NCH; i++)
      begin
        if (fail_mode || direct_input_filtered[i])
          channel_out[i] <= direct_input_filtered[i];
        else if (clk_cond_reg)
          channel_out[i] <= channel_control_signal[i];
        else
          channel_out[i] <= pwm_drive[i];
      end
  end

  // Switch drive off in sleep or fail mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      external_switch_drive <= 1'b0;
    else
      external_switch_drive <= awake && !fail_mode && ch6_reg;
  end

  // ==========================================================================
  // APB registers and interrupts
  // ==========================================================================
  logic [lsf_pkg::IRQ_W-1:0] irq_stat_reg, irq_mask_reg, irq_set;
  logic wr_acc, rd_acc, setup, mapped;
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign mapped = paddr == lsf_pkg::CTRL_OFF || paddr == lsf_pkg::DEVSTAT_OFF || paddr == lsf_pkg::QSTAT_OFF ||
                  paddr == lsf_pkg::IRQ_STAT_OFF || paddr == lsf_pkg::IRQ_MASK_OFF;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign qstat_read = rd_acc && paddr == lsf_pkg::QSTAT_OFF;
  assign resume_req = wr_acc && paddr == lsf_pkg::CTRL_OFF && pwdata[lsf_pkg::CTRL_RESUME];
  assign irq_set = {clk_cond_reg && !clk_fail_reg, (link_fault_evt || failsafe_request_filtered) && !fail_mode,
                    link_fault_evt};
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // Control and mask registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      range_sel_reg <= lsf_pkg::CTRL_RANGE_RST;
      irq_mask_reg <= lsf_pkg::IRQ_MASK_RST;
    end
    else if (wr_acc && paddr == lsf_pkg::CTRL_OFF)
      range_sel_reg <= pwdata[lsf_pkg::CTRL_RANGE_SEL];
    else if (wr_acc && paddr == lsf_pkg::IRQ_MASK_OFF)
      irq_mask_reg <= pwdata[lsf_pkg::IRQ_W-1:0];
  end

  // Sticky status, write one clears, a new event wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat_reg <= '0;
    else if (wr_acc && paddr == lsf_pkg::IRQ_STAT_OFF)
      irq_stat_reg <= (irq_stat_reg & ~pwdata[lsf_pkg::IRQ_W-1:0]) | irq_set;
    else
      irq_stat_reg <= irq_stat_reg | irq_set;
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (setup && !pwrite)
      unique case (paddr)
        lsf_pkg::CTRL_OFF: prdata <= {31'h00000000, range_sel_reg};
        lsf_pkg::DEVSTAT_OFF: prdata <= {25'h0000000, len_err_reg, wd_err_reg, tog_err_reg, !awake, fail_mode,
                                         s_req, link_fault_flag};
        lsf_pkg::QSTAT_OFF: prdata <= {30'h00000000, clk_cond_reg, clk_fail_reg};
        lsf_pkg::IRQ_STAT_OFF: prdata <= {29'h00000000, irq_stat_reg};
        lsf_pkg::IRQ_MASK_OFF: prdata <= {29'h00000000, irq_mask_reg};
        default: prdata <= 32'h00000000;
      endcase
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_fault;
    link_fault_evt;
  endsequence
  sequence s_in_fail_flagged;
    fail_mode && link_fault_flag;
  endsequence
  chk_fault_enters_fail: assert property (s_fault |=> s_in_fail_flagged)
    else $error("link fault did not enter fail mode with flag");
  chk_alive_same_fault: assert property (word_done && alive_seen_reg &&
    word[lsf_pkg::ALIVE_BIT] == alive_prev_reg |=> link_fault_flag)
    else $error("repeated alive bit not flagged");
  chk_wd_expiry: assert property (awake && !valid_frame && wd_cnt_reg == wd_limit |=> fail_mode)
    else $error("watchdog expiry did not force fail mode");
  chk_len_error: assert property (frame_end && bit_cnt_reg != 4'h0 |=> link_fault_flag && len_err_reg)
    else $error("length error not flagged");
  chk_flag_held: assert property (fail_mode && link_fault_flag && !leave_fail |=> link_fault_flag)
    else $error("link fault flag dropped while in fail mode");
  chk_req_forces_fail: assert property ($rose(failsafe_request_filtered) |-> ##1 fail_mode [*3])
    else $error("filtered request did not hold fail mode");
  chk_drive_off_fail: assert property (fail_mode || !awake |=> !external_switch_drive)
    else $error("switch drive on in fail or sleep mode");
  chk_fail_direct: assert property (fail_mode |=> channel_out == $past(direct_input_filtered))
    else $error("fail mode channel not following direct input");
  chk_clk_latch_hold: assert property (clk_fail_reg && !qstat_read |=> clk_fail_reg)
    else $error("clock fail latch cleared without read");
  chk_sleep_monitor: assert property (!awake |=> cm_cnt_reg == '0 && !clk_cond_reg)
    else $error("clock monitor ran during sleep");
endmodule

//--- verilog/lsf_pkg.sv
// Constants shared by the link supervisor: register map, fields, reset values, timing
package lsf_pkg;
  // ==========================================================================
  // Clock and timing figures
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 40; // pclk period in ns
  localparam int IN_DGL_US = 200; // Request and direct input deglitch, typical
  localparam int RST_DGL_US = 10; // Reset pin falling edge deglitch, typical
  localparam int CLK_DGL_NS = 2000; // Clock pin deglitch, both edges, typical
  localparam int WD_SHORT_MS = 32; // Watchdog period with range select 0
  localparam int WD_LONG_MS = 128; // Watchdog period with range select 1
  localparam int CLK_LOW_HZ = 100; // Clock low frequency limit
  // Cycle counts derived from the figures above
  localparam int IN_DGL_CYC = (IN_DGL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_DGL_CYC = (RST_DGL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLK_DGL_CYC = (CLK_DGL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WD_SHORT_CYC = (WD_SHORT_MS * 1000000) / CLK_PERIOD_NS;
  localparam int WD_LONG_CYC = (WD_LONG_MS * 1000000) / CLK_PERIOD_NS;
  localparam int CLK_LOW_CYC = (1000000000 / CLK_LOW_HZ) / CLK_PERIOD_NS;
  // ==========================================================================
  // Serial frame layout
  // ==========================================================================
  localparam int FRAME_BITS = 16; // Word length on the link
  localparam int ALIVE_BIT = 15; // Position of alive_toggle_bit in a word
  localparam int CH6_BIT = 5; // Channel 6 on/off setting in a word
  // ==========================================================================
  // Register offsets (byte addresses)
  // ==========================================================================
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] DEVSTAT_OFF = 8'h04;
  localparam logic [7:0] QSTAT_OFF = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h10;
  // Control fields
  localparam int CTRL_RANGE_SEL = 0; // timeout_range_select
  localparam int CTRL_RESUME = 1; // Write one: leave fail mode
  // Device status fields
  localparam int DS_LINK_FAULT = 0; // link_fault_flag
  localparam int DS_PIN_LEVEL = 1; // failsafe_pin_level_bit
  localparam int DS_FAIL_MODE = 2;
  localparam int DS_SLEEP = 3;
  localparam int DS_TOG_ERR = 4;
  localparam int DS_WD_ERR = 5;
  localparam int DS_LEN_ERR = 6;
  // Quick status fields
  localparam int QS_CLK_FAIL = 0; // Latched clock failure
  localparam int QS_CLK_COND = 1; // Live clock failure condition
  // Interrupt bits
  localparam int IRQ_W = 3;
  localparam int IRQ_LINK = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_CLK = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  localparam logic CTRL_RANGE_RST = 1'b0;
endpackage

//--- verif/lsf_host_model.sv
// Host model: serial master that drives the link pins of the supervisor
`timescale 1ns/100ps
module lsf_host_model (
  // Link pins
  output logic link_sclk,
  output logic link_cs_n,
  output logic link_mosi
);
  // Idle: deselected, clock parked low
  initial
  begin
    link_sclk = 1'b0;
    link_cs_n = 1'b1;
    link_mosi = 1'b1;
  end
  // Sends nb bits MSB first; the 320 ns clock runs only inside the frame
  task automatic frame(input logic [31:0] w, input int nb);
    link_cs_n = 1'b0;
    for (int i = nb - 1; i >= 0; i--)
    begin
      link_mosi = w[i];
      #160 link_sclk = 1'b1;
      #160 link_sclk = 1'b0;
    end
    #160 link_cs_n = 1'b1;
    link_mosi = ~link_mosi; // Released line shows the inverse
    #320;
  endtask
endmodule

//--- verif/lsf_link_supervisor_tb.sv
// Self-checking bench for the link supervisor
`timescale 1ns/100ps
module lsf_link_supervisor_tb;
  // Stimulus and observed signals
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic fsreq = 1'b0, rpin = 1'b0, eclk = 1'b0, erun = 1'b1, alive = 1'b0, ch6;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, w;
  logic pready, pslverr, err, sclk, cs_n, mosi, drv, fm, irq;
  logic [3:0] din = 4'h0, ctl = 4'h0, pwm = 4'h0, cout;
  int num_errors = 0, check_count = 0, n;
  localparam logic [7:0] CT = lsf_pkg::CTRL_OFF, DS = lsf_pkg::DEVSTAT_OFF, QS = lsf_pkg::QSTAT_OFF;
  localparam logic [7:0] IS = lsf_pkg::IRQ_STAT_OFF, IM = lsf_pkg::IRQ_MASK_OFF;
  // Bus clock and a slow external clock that the monitor accepts
  always #20 pclk = ~pclk;
  always @(posedge pclk) eclk <= (erun && $time % 3200 < 40) ? ~eclk : eclk;
  lsf_link_supervisor #(.IN_DGL_CYC(20), .WD_SHORT_CYC(400), .WD_LONG_CYC(1600), .CLK_LOW_CYC(300))
    u_lsf_link_supervisor (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_sclk(sclk),
    .link_cs_n(cs_n), .link_mosi(mosi), .failsafe_request_input(fsreq), .direct_channel_input(din),
    .reset_sleep_n(rpin), .ext_clk_in(eclk), .channel_control_signal(ctl), .pwm_drive(pwm),
    .channel_out(cout), .external_switch_drive(drv), .fail_mode(fm), .irq(irq));
  lsf_host_model u_lsf_host_model (.link_sclk(sclk), .link_cs_n(cs_n), .link_mosi(mosi));
  // Verdict and end of run
  task automatic summarize();
    if (num_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Compare seen against expected
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) num_errors++;
    if (got !== exp) $display("mismatch at %0t: saw %h want %h", $time, got, exp);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  // One APB transfer: setup, access until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (n = 0; pready !== 1'b1 && n < 50; n++) @(posedge pclk);
    if (n == 50) chk(1, 0);
    if (n == 50) summarize();
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  // Frame of nb bits; flip keeps the alive bit toggling
  task automatic send(input int nb, input logic flip, input logic c = 1'b1);
    alive = alive ^ flip;
    w = $urandom;
    w[nb-1] = alive;
    w[nb-11] = c;
    ch6 = c;
    u_lsf_host_model.frame(w, nb);
  endtask
  // Random direct, control and PWM levels against the channel mux
  task automatic chan(input logic f, input logic cf);
    repeat (4)
    begin
      {din, ctl, pwm} <= 12'($urandom);
      cyc(30);
      chk(cout, din | (f ? 4'h0 : (cf ? ctl : pwm)));
    end
  endtask
  // Watchdog expiry measured from the end of a good frame
  task automatic wdog(input int cy);
    send(16, 1'b1);
    for (n = 0; fm !== 1'b1 && n < cy + 50; n++) @(posedge pclk);
    chk(n > cy - 20 && n < cy + 10, 1);
    if (fm !== 1'b1) summarize();
  endtask
  // Main sequence
  initial
  begin
    void'($urandom(32'hA2427D64));
    cyc(2);
    presetn <= 1'b1;
    rdc(CT, 32'hFFFFFFFF, 32'h0);
    rdc(IM, 32'hFFFFFFFF, 32'h0);
    rdc(8'h14, 32'hFFFFFFFF, 32'h0);
    chk(err, 1'b1);
    rpin <= 1'b1;
    apb(1'b1, CT, 32'h1);
    apb(1'b1, IM, 32'h7);
    repeat (3)
    begin
      send(16, 1'b1, 1'($urandom));
      cyc(5);
      chk(drv, ch6);
    end
    chan(1'b0, 1'b0);
    send(16, 1'b1);
    send(16, 1'b0);
    cyc(5);
    chk({fm, drv, irq}, 3'b101);
    rdc(DS, 32'h75, 32'h15);
    chan(1'b1, 1'b0);
    apb(1'b1, IM, 32'h0);
    cyc(1);
    chk(irq, 1'b0);
    apb(1'b1, IS, 32'h7);
    rdc(IS, 32'h7, 32'h0);
    rdc(DS, 32'h1, 32'h1);
    apb(1'b1, CT, 32'h3);
    rdc(DS, 32'h5, 32'h0);
    send(16, 1'b1);
    send(17, 1'b1);
    cyc(5);
    rdc(DS, 32'h45, 32'h45);
    apb(1'b1, CT, 32'h3);
    wdog(1600);
    rdc(DS, 32'h20, 32'h20);
    apb(1'b1, CT, 32'h2);
    wdog(400);
    apb(1'b1, CT, 32'h3);
    send(16, 1'b1);
    erun <= 1'b0;
    cyc(400);
    rdc(QS, 32'h3, 32'h3);
    rdc(QS, 32'h3, 32'h3);
    chan(1'b0, 1'b1);
    erun <= 1'b1;
    cyc(160);
    chan(1'b0, 1'b0);
    rdc(QS, 32'h3, 32'h1);
    rdc(QS, 32'h3, 32'h0);
    chan(1'b0, 1'b0);
    fsreq <= 1'b1;
    cyc(10);
    fsreq <= 1'b0;
    cyc(30);
    chk(fm, 1'b0);
    fsreq <= 1'b1;
    cyc(3);
    rdc(DS, 32'h2, 32'h2);
    cyc(30);
    chk(fm, 1'b1);
    fsreq <= 1'b0;
    cyc(3);
    apb(1'b1, CT, 32'h3);
    rpin <= 1'b0;
    cyc(100);
    rdc(DS, 32'h8, 32'h0);
    cyc(200);
    rdc(DS, 32'h8, 32'h8);
    chk(drv, 1'b0);
    rpin <= 1'b1;
    cyc(5);
    rdc(DS, 32'h8, 32'h0);
    summarize();
  end
endmodule
